/* File: common/pbiu_pkg.sv */
// Package for the prefetch bus interface unit: register map, fields, types
package pbiu_pkg;
  // Register offsets (Wishbone byte addresses, one byte each)
  localparam logic [7:0] PBIU_OFS_MODE0  = 8'h5e;
  localparam logic [7:0] PBIU_OFS_MODE1  = 8'h5f;
  localparam logic [7:0] PBIU_OFS_STATUS = 8'h60;
  // Field positions and reset values
  localparam int         PBIU_WAIT_BIT   = 2;
  localparam int         PBIU_STYLE_BIT  = 0;
  localparam logic [7:0] PBIU_MODE0_RST  = 8'h00;
  localparam logic [7:0] PBIU_MODE1_RST  = 8'h00;
  // Queue length and fill count codes
  localparam int         PBIU_QUEUE_LEN  = 3;
  localparam logic [1:0] PBIU_Q_EMPTY    = 2'h0;
  localparam logic [1:0] PBIU_Q_ONE      = 2'h1;
  // Internal memory region: addresses below this limit are on chip
  localparam logic [23:0] PBIU_INT_LIMIT = 24'h008000;

  // Bus cycle phases: address, access, extra halves for waits
  typedef enum logic [2:0] {
    PH_IDLE, PH_ALE, PH_ALE_X, PH_ACC, PH_ACC_X1, PH_ACC_X2, PH_ACC_X3
  } pbiu_phase_t;

  // Kind of the bus cycle in flight
  typedef enum logic [1:0] { K_FETCH, K_READ, K_WRITE } pbiu_kind_t;

  // Core data request group
  typedef struct packed {
    logic        req;
    logic        we;
    logic        wide;
    logic [23:0] addr;
    logic [15:0] wdata;
  } pbiu_dreq_t;

  // External bus outputs
  typedef struct packed {
    logic [23:0] addr;
    logic        ale;
    logic        access_n;
    logic        rd_wr;
    logic        address_bit_zero;
    logic        high_byte_enable_n;
    logic [15:0] dout;
    logic [15:0] doe;
  } pbiu_bus_t;
endpackage : pbiu_pkg

/* File: logic/pbiu_top.sv */
// Prefetch bus interface unit: queue, data buffer, bus sequencer, registers
`timescale 1ns/1ns
module pbiu_top
  import pbiu_pkg::*;
(
  input  wire logic        sys_clk,       // Oscillator clock, 100 MHz
  input  wire logic        rstn,          // Synchronous reset, active low
  // Wishbone slave
  input  wire logic        wb_cyc_i,      // Bus cycle
  input  wire logic        wb_stb_i,      // Strobe
  input  wire logic        wb_we_i,       // Write enable
  input  wire logic [7:0]  wb_adr_i,      // Byte address
  input  wire logic [3:0]  wb_sel_i,      // Byte lanes
  input  wire logic [31:0] wb_dat_i,      // Write data
  output logic      [31:0] wb_dat_o,      // Read data
  output logic             wb_ack_o,      // Acknowledge
  // Core side
  output logic             core_clk_en,   // Core clock enable, half rate
  input  wire logic        redirect,      // Program flow change
  input  wire logic [23:0] redirect_addr, // New bank and counter
  input  wire logic        fetch_req,     // Core wants instruction bytes
  input  wire logic [1:0]  fetch_cnt,     // Bytes wanted, 1 or 2
  output logic      [15:0] fetch_data,    // Oldest queue bytes
  output logic             fetch_stall,   // Core must hold
  input  wire pbiu_dreq_t  dreq,          // Core data request
  output logic             data_stall,    // Data request not accepted
  output logic      [15:0] rdata,         // Data buffer contents
  output logic             rdata_valid,   // Read data complete pulse
  // External memory bus
  input  wire logic        byte_mode,     // Pin: high selects 8-bit bus
  input  wire logic [15:0] bus_din,       // Pin: data in
  output pbiu_bus_t        bus            // Bus outputs
);

  ////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic is_internal(input logic [23:0] a);
    return a < PBIU_INT_LIMIT;
  endfunction : is_internal

  // Two bytes at once: even address and a 16-bit path
  function automatic logic pair_ok(input logic [23:0] a, input logic narrow);
    return !a[0] && (is_internal(a) || !narrow);
  endfunction : pair_ok

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser for the width select
  // The width pin is set by the board and may change at any time;
  // only the second stage feeds lane decisions, so a change lands
  // cleanly at the start of some later bus cycle.
  logic byte_s1_q, byte_s2_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      byte_s1_q <= 1'b0;
      byte_s2_q <= 1'b0;
    end else begin
      byte_s1_q <= byte_mode;
      byte_s2_q <= byte_s1_q;
    end
  end

  logic div_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) div_q <= 1'b0;
    else       div_q <= ~div_q;
  end
  assign core_clk_en = div_q;

  ////////////////////////////////////////////////////////////////////
  // Mode registers and Wishbone slave
  logic [7:0] mode0_q, mode1_q;
  logic       ack_q;
  logic       wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode0_q <= PBIU_MODE0_RST;
      mode1_q <= PBIU_MODE1_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == PBIU_OFS_MODE0) mode0_q <= wb_dat_i[7:0];
      if (wb_adr_i == PBIU_OFS_MODE1) mode1_q <= wb_dat_i[7:0];
    end
  end

  // One-cycle ack; unmapped reads return zero
  // The ack register blocks a second take of the same request, so a
  // master that holds stb through the ack edge is served only once.
  // Read data is registered with the ack and stands for that cycle.
  logic [1:0] qcnt_q;
  logic       busy;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_q    <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          PBIU_OFS_MODE0:  wb_dat_o <= {24'h0, mode0_q};
          PBIU_OFS_MODE1:  wb_dat_o <= {24'h0, mode1_q};
          PBIU_OFS_STATUS: wb_dat_o <= {29'h0, busy, qcnt_q};
          default:         wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;

  ////////////////////////////////////////////////////////////////////
  // Storage: program address, queue, data address and buffer
  // unit registers
  logic [15:0] program_counter_q;
  logic [7:0]  program_bank_q;
  logic [7:0]  queue_q [PBIU_QUEUE_LEN];
  logic [23:0] daddr_q;
  logic [15:0] dbuf_q;
  logic        dpend_q, dwe_q, dwide_q, dhalf_q;

  pbiu_phase_t ph_q;
  pbiu_kind_t  kind_q;
  logic [23:0] cyc_addr_q;
  logic        cyc_two_q;   // Both lanes in this cycle
  logic        stretch_q;   // Wait applies to this cycle

  assign busy = (ph_q != PH_IDLE);

  // Decide the next cycle; data beats prefetch
  // Starts happen only on a core clock edge, so each bus phase spans
  // two oscillator clocks. A pending data request always wins, since
  // the core may be stalled on it while prefetch is only speculative.
  // No fetch starts in the redirect cycle: its address is stale.
  logic start_data, start_fetch, fetch_want, fetch_two;
  logic [23:0] pa;
  assign pa = {program_bank_q, program_counter_q};
  // even fetch pairs / narrow external single / odd or last-slot single
  assign fetch_two = pair_ok(pa, byte_s2_q) && (qcnt_q != PBIU_Q_ONE + PBIU_Q_ONE);
  assign fetch_want = (qcnt_q == PBIU_Q_EMPTY) || (qcnt_q == PBIU_Q_ONE && !dpend_q)
                      || (fetch_req && fetch_stall);
  assign start_data  = !busy && dpend_q && div_q;
  assign start_fetch = !busy && !dpend_q && fetch_want && !redirect && div_q
                       && (qcnt_q < 2'(PBIU_QUEUE_LEN));

  // data stall while buffer pending
  assign data_stall = dreq.req && dpend_q;
  assign fetch_stall = fetch_req && (qcnt_q < fetch_cnt);
  assign fetch_data  = {queue_q[1], queue_q[0]};

  // Accepted data request, current data lane plan
  logic        dacc;
  logic        d_two;
  logic [23:0] d_addr;
  assign dacc   = dreq.req && !dpend_q;
  assign d_addr = dhalf_q ? daddr_q + 24'h1 : daddr_q;
  // pair condition / split otherwise / internal wide
  assign d_two  = dwide_q && !dhalf_q && pair_ok(daddr_q, byte_s2_q);

  ////////////////////////////////////////////////////////////////////
  // Bus sequencer: ALE half then access half, each one core clock unless the cycle is stretched
  logic wait_on, style1, cyc_end;
  assign wait_on = !mode0_q[PBIU_WAIT_BIT];   // wait when zero
  assign style1  = mode1_q[PBIU_STYLE_BIT];
  // style 1: one extra access core clock, 1.5x cycle
  // style 0: extra latch and access clock, 2x cycle
  // The last two access phases stay unused; running into them would
  // stretch the doubled cycle to three times its plain length.
  assign cyc_end = (ph_q == PH_ACC && !stretch_q)
                   || (ph_q == PH_ACC_X1);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ph_q       <= PH_IDLE;
      kind_q     <= K_FETCH;
      cyc_addr_q <= 24'h0;
      cyc_two_q  <= 1'b0;
      stretch_q  <= 1'b0;
    end else if (div_q) begin
      case (ph_q)
        PH_IDLE: begin
          if (start_data) begin
            ph_q       <= PH_ALE;
            kind_q     <= dwe_q ? K_WRITE : K_READ;
            cyc_addr_q <= d_addr;
            cyc_two_q  <= d_two;
            // internal never / wait bit zero
            stretch_q  <= wait_on && !is_internal(d_addr);
          end else if (start_fetch) begin
            ph_q       <= PH_ALE;
            kind_q     <= K_FETCH;
            cyc_addr_q <= pa;
            cyc_two_q  <= fetch_two;
            stretch_q  <= wait_on && !is_internal(pa);
          end
        end
        // style zero stretches latch strobe too
        PH_ALE:    ph_q <= (stretch_q && !style1) ? PH_ALE_X : PH_ACC;
        PH_ALE_X:  ph_q <= PH_ACC;
        PH_ACC:    ph_q <= stretch_q ? PH_ACC_X1 : PH_IDLE;
        PH_ACC_X1: ph_q <= PH_IDLE;
        PH_ACC_X2: ph_q <= PH_ACC_X3;
        PH_ACC_X3: ph_q <= PH_IDLE;
        default:   ph_q <= PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data request buffer: posted writes, reads waited for
  // Only one request is held at a time; a new one is stalled until
  // the last byte cycle of the previous one ends. Split transfers
  // take the low byte first, then the byte at the next address.
  logic [15:0] lanes;
  assign lanes = cyc_addr_q[0] ? {bus_din[15:8], bus_din[15:8]} : bus_din;
  logic dfinish;
  assign dfinish = div_q && cyc_end && kind_q != K_FETCH;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dpend_q     <= 1'b0;
      dwe_q       <= 1'b0;
      dwide_q     <= 1'b0;
      dhalf_q     <= 1'b0;
      daddr_q     <= 24'h0;
      dbuf_q      <= 16'h0;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= 1'b0;
      if (dacc) begin
        dpend_q <= 1'b1;
        dwe_q   <= dreq.we;
        dwide_q <= dreq.wide;
        dhalf_q <= 1'b0;
        daddr_q <= dreq.addr;
        dbuf_q  <= dreq.wdata;
      end else if (dfinish) begin
        if (kind_q == K_READ) begin
          if (cyc_two_q)    dbuf_q       <= bus_din;
          else if (dhalf_q) dbuf_q[15:8] <= lanes[7:0];
          else              dbuf_q[7:0]  <= cyc_addr_q[0] ? bus_din[15:8] : bus_din[7:0];
        end
        if (dwide_q && !dhalf_q && !cyc_two_q) begin
          dhalf_q <= 1'b1;
        end else begin
          dpend_q     <= 1'b0;
          rdata_valid <= !dwe_q;
        end
      end
    end
  end
  assign rdata = dbuf_q;

  ////////////////////////////////////////////////////////////////////
  // Instruction queue and program address
  // Pushes and pops may fall in one cycle; the pushed bytes go in at
  // the old count and the shift for the pop follows, so the count
  // never passes the queue length.
  logic ffinish;
  logic [1:0] pop, push;
  assign ffinish = div_q && cyc_end && kind_q == K_FETCH;

  // stale fetch discard
  // A redirect can land while a fetch is still on the bus; the cycle
  // runs to its end, but its bytes belong to the old flow and must
  // neither enter the queue nor advance the program address.
  logic flush_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flush_q <= 1'b0;
    end else if (redirect && busy && !(div_q && cyc_end)) begin
      flush_q <= 1'b1;
    end else if (div_q && cyc_end) begin
      flush_q <= 1'b0;
    end
  end

  assign push = (ffinish && !flush_q) ? (cyc_two_q ? 2'd2 : 2'd1) : 2'd0;
  assign pop  = (fetch_req && !fetch_stall) ? fetch_cnt : 2'd0;

  always_ff @(posedge sys_clk) begin
    if (!rstn || redirect) begin
      qcnt_q            <= PBIU_Q_EMPTY;
      program_counter_q <= rstn ? redirect_addr[15:0] : 16'h0;
      program_bank_q    <= rstn ? redirect_addr[23:16] : 8'h0;
      for (int i = 0; i < PBIU_QUEUE_LEN; i++) queue_q[i] <= 8'h0;
    end else begin
      logic [7:0] tmp [PBIU_QUEUE_LEN + 2];
      logic [16:0] inc;
      for (int i = 0; i < PBIU_QUEUE_LEN + 2; i++) tmp[i] = 8'h0;
      for (int i = 0; i < PBIU_QUEUE_LEN; i++) tmp[i] = queue_q[i];
      // append both bytes / one byte
      if (push != 2'd0) begin
        tmp[qcnt_q] = cyc_addr_q[0] ? bus_din[15:8] : bus_din[7:0];
        if (cyc_two_q) tmp[qcnt_q + 2'd1] = bus_din[15:8];
      end
      for (int i = 0; i < PBIU_QUEUE_LEN; i++)
        queue_q[i] <= (pop == 2'd2) ? tmp[i + 2] : (pop == 2'd1) ? tmp[i + 1] : tmp[i];
      qcnt_q <= qcnt_q + push - pop;
      inc = {1'b0, program_counter_q} + {15'h0, push};
      program_counter_q <= inc[15:0];
      program_bank_q    <= program_bank_q + {7'h0, inc[16]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus output drive
  // All strobes decode registered state, so they cannot glitch.
  // The data lanes are driven only in the access phase of a write,
  // leaving the latch phase free for the address on the shared pins.
  logic in_ale, in_acc;
  assign in_ale = (ph_q == PH_ALE) || (ph_q == PH_ALE_X);
  assign in_acc = (ph_q == PH_ACC) || (ph_q == PH_ACC_X1) ||
                  (ph_q == PH_ACC_X2) || (ph_q == PH_ACC_X3);

  always_comb begin
    bus.addr = cyc_addr_q;
    bus.ale  = in_ale;
    bus.access_n = !in_acc;
    bus.rd_wr = !(busy && kind_q == K_WRITE);
    bus.address_bit_zero   = cyc_addr_q[0];
    bus.high_byte_enable_n = !(busy && (cyc_two_q || cyc_addr_q[0]));
    bus.dout = cyc_two_q ? dbuf_q :
               (dhalf_q ? {dbuf_q[15:8], dbuf_q[15:8]} : {dbuf_q[7:0], dbuf_q[7:0]});
    bus.doe  = (in_acc && kind_q == K_WRITE) ? 16'hffff : 16'h0000;
  end

endmodule : pbiu_top

/* File: testbench/pbiu_asserts.sv */
// Checker for the bus strobes of the prefetch bus unit
`timescale 1ns/1ns
module pbiu_asserts
  import pbiu_pkg::*;
(
  input wire logic       sys_clk,     // Clock
  input wire logic       rstn,        // Reset, low
  input wire logic       core_clk_en, // Half rate
  input wire pbiu_dreq_t dreq,        // Data request
  input wire logic       data_stall,  // Data hold
  input wire logic       rdata_valid, // Read done
  input wire logic       byte_mode,   // Bus width pin
  input wire pbiu_bus_t  bus          // Bus outputs
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Cycle is external when above on-chip space
  wire logic is_ext = bus.addr >= PBIU_INT_LIMIT;
  ////////////////////////////////////////////////////////////////
  clk_half_a: assert property (core_clk_en |=> !core_clk_en)
    else $error("core enable not halved");
  ale_phase_a: assert property (bus.ale |-> bus.access_n)
    else $error("latch strobe during access");
  ale_min_a: assert property ($rose(bus.ale) |=> bus.ale)
    else $error("latch strobe too short");
  strobe_min_a: assert property ($fell(bus.access_n) |=> !bus.access_n)
    else $error("access strobe too short");
  int_nowait_a: assert property ($fell(bus.access_n) && !is_ext |-> ##2 bus.access_n)
    else $error("internal access stretched");
  lane_bit_a: assert property (!bus.access_n |-> bus.address_bit_zero == bus.addr[0])
    else $error("bit zero off address");
  odd_lane_a: assert property (!bus.access_n && bus.address_bit_zero |-> !bus.high_byte_enable_n)
    else $error("odd byte without high enable");
  byte_bus_a: assert property (!bus.access_n && is_ext && byte_mode && $past(byte_mode, 4)
    |-> bus.address_bit_zero || bus.high_byte_enable_n)
    else $error("two bytes on narrow bus");
  drive_dir_a: assert property ((bus.doe != 16'h0000) == (!bus.access_n && !bus.rd_wr))
    else $error("data drive outside write");
  read_done_a: assert property (dreq.req && !dreq.we && !data_stall |-> ##[4:40] rdata_valid)
    else $error("read never completed");
  write_go_a: assert property (dreq.req && dreq.we && !data_stall
    |-> ##[1:40] (!bus.access_n && !bus.rd_wr))
    else $error("posted write never ran");
  cover property ($rose(rdata_valid));
  cover property (is_ext && $fell(bus.access_n));
  cover property (!bus.access_n && !bus.rd_wr);
endmodule : pbiu_asserts

bind pbiu_top pbiu_asserts u_chk (.sys_clk(sys_clk), .rstn(rstn), .core_clk_en(core_clk_en),
  .dreq(dreq), .data_stall(data_stall), .rdata_valid(rdata_valid), .byte_mode(byte_mode),
  .bus(bus));

/* File: testbench/pbiu_mem_model.sv */
// Memory model on the far side of the multiplexed bus
`timescale 1ns/1ns
module pbiu_mem_model
  import pbiu_pkg::*;
(
  input  wire logic      sys_clk, // Clock
  input  wire pbiu_bus_t bus,     // Bus from the unit
  output logic    [15:0] bus_din  // Data to the unit
);
  logic [7:0]  mem [logic [23:0]];
  logic [23:0] lat_q;
  wire  [23:0] la = bus.ale ? bus.addr : lat_q;
  // Unwritten bytes follow an address pattern
  function automatic logic [7:0] rd(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ a[23:16]);
  endfunction : rd
  initial bus_din = 16'h5a5a;
  ////////////////////////////////////////////////////////////////
  // address taken only in the latch phase
  always @(posedge sys_clk) begin
    if (bus.ale)
      lat_q <= bus.addr;
    // lanes chosen by bit zero and high enable
    if (!bus.access_n && !bus.rd_wr && !bus.address_bit_zero)
      mem[{lat_q[23:1], 1'b0}] = bus.dout[7:0];
    if (!bus.access_n && !bus.rd_wr && !bus.high_byte_enable_n)
      mem[{lat_q[23:1], 1'b1}] = bus.dout[15:8];
    // Released lines toggle so a stale sample never matches
    if (bus.rd_wr && (bus.ale || !bus.access_n))
      bus_din <= {rd({la[23:1], 1'b1}), rd(la)};
    else
      bus_din <= ~bus_din;
  end
endmodule : pbiu_mem_model

/* File: testbench/pbiu_top_test.sv */
// Self-checking bench for the prefetch bus interface unit
`timescale 1ns/1ns
module pbiu_top_test
  import pbiu_pkg::*;
;
  logic        sys_clk, rstn, cyc, stb, we, redirect, fetch_req, byte_mode;
  logic        wb_ack_o, core_clk_en, fetch_stall, data_stall, rdata_valid;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, wb_dat_o;
  logic [23:0] redirect_addr;
  logic [1:0]  fetch_cnt;
  logic [15:0] fetch_data, rdata, bus_din;
  pbiu_dreq_t  dreq;
  pbiu_bus_t   bus;
  int          n_fail, checked;

  pbiu_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_clk_en(core_clk_en), .redirect(redirect), .redirect_addr(redirect_addr),
    .fetch_req(fetch_req), .fetch_cnt(fetch_cnt), .fetch_data(fetch_data),
    .fetch_stall(fetch_stall), .dreq(dreq), .data_stall(data_stall), .rdata(rdata),
    .rdata_valid(rdata_valid), .byte_mode(byte_mode), .bus_din(bus_din), .bus(bus));
  pbiu_mem_model u_mem (.sys_clk(sys_clk), .bus(bus), .bus_din(bus_din));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction : pat
  task automatic finish_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // One clock of a bounded wait; running out ends the run
  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 300) begin
      n_fail++;
      finish_test();
    end
  endtask : tick
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h1;
    do tick(n); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask : wb
  // Redirect, then leave time for the queue to settle
  task automatic redir(input logic [23:0] a);
    redirect <= 1'b1;
    redirect_addr <= a;
    @(posedge sys_clk);
    redirect <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask : redir
  task automatic fetch(input logic [1:0] c, input logic [15:0] exp);
    int n = 0;
    fetch_req <= 1'b1;
    fetch_cnt <= c;
    do tick(n); while (fetch_stall !== 1'b0);
    cmp(c == 2'h1 ? {8'h00, fetch_data[7:0]} : fetch_data, exp);
    fetch_req <= 1'b0;
    @(posedge sys_clk);
  endtask : fetch
  // Read and count latch and access clocks until the buffer is full
  task automatic rd(input logic [23:0] a, input logic wide, input logic [15:0] exp,
                    input int cy, input int ale_w, input int acc_w);
    int n = 0;
    int ale_c = 0;
    int acc_c = 0;
    dreq <= '{1'b1, 1'b0, wide, a, 16'h0000};
    do tick(n); while (data_stall !== 1'b0);
    dreq.req <= 1'b0;
    do begin
      tick(n);
      ale_c += bus.ale;
      acc_c += !bus.access_n;
    end while (rdata_valid !== 1'b1);
    cmp(wide ? rdata : {8'h00, rdata[7:0]}, exp);
    cmp(ale_c, cy * ale_w);
    cmp(acc_c, cy * acc_w);
  endtask : rd
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    int n = 0;
    dreq <= '{1'b1, 1'b1, 1'b1, a, d};
    do tick(n); while (data_stall !== 1'b0);
    dreq.req <= 1'b0;
    cmp(bus.access_n, 1'b1);
    @(posedge sys_clk);
  endtask : wr
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] q;
    wb(1'b0, PBIU_OFS_MODE0, 32'h0, q);
    cmp(q[7:0], PBIU_MODE0_RST);
    wb(1'b0, PBIU_OFS_MODE1, 32'h0, q);
    cmp(q[7:0], PBIU_MODE1_RST);
    wb(1'b1, 8'h70, 32'hff, q);
    wb(1'b0, 8'h70, 32'h0, q);
    cmp(q, 32'h0);
    $display("registers done");
  endtask : t_regs
  task automatic t_queue;
    logic [31:0] q;
    redir(24'h001000);
    wb(1'b0, PBIU_OFS_STATUS, 32'h0, q);
    cmp(q[2:0], 3'h2);
    redir(24'h001001);
    wb(1'b0, PBIU_OFS_STATUS, 32'h0, q);
    cmp(q[2:0], 3'h3);
    fetch(2'h1, pat(24'h001001));
    fetch(2'h2, {pat(24'h001003), pat(24'h001002)});
    redir(24'h01fffe);
    fetch(2'h2, {pat(24'h01ffff), pat(24'h01fffe)});
    fetch(2'h2, {pat(24'h020001), pat(24'h020000)});
    $display("queue done");
  endtask : t_queue
  task automatic t_wait;
    logic [31:0] q;
    redir(24'h001000);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, PBIU_OFS_MODE0, 32'(m[1]) << PBIU_WAIT_BIT, q);
      wb(1'b1, PBIU_OFS_MODE1, 32'(m[0]) << PBIU_STYLE_BIT, q);
      wb(1'b0, PBIU_OFS_MODE0, 32'h0, q);
      cmp(q[7:0], 32'(m[1]) << PBIU_WAIT_BIT);
      rd(24'h002000, 1'b1, {pat(24'h002001), pat(24'h002000)}, 1, 2, 2);
      rd(24'h040000, 1'b1, {pat(24'h040001), pat(24'h040000)}, 1, (m[1] | m[0]) ? 2 : 4,
         m[1] ? 2 : 4);
    end
    $display("waits done");
  endtask : t_wait
  task automatic t_data;
    rd(24'h040003, 1'b1, {pat(24'h040004), pat(24'h040003)}, 2, 2, 2);
    // narrow bus selected by the pin
    byte_mode <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(24'h040010, 1'b1, {pat(24'h040011), pat(24'h040010)}, 2, 2, 2);
    rd(24'h002010, 1'b1, {pat(24'h002011), pat(24'h002010)}, 1, 2, 2);
    rd(24'h002011, 1'b0, pat(24'h002011), 1, 2, 2);
    byte_mode <= 1'b0;
    repeat (8) @(posedge sys_clk);
    wr(24'h040021, 16'hbeef);
    rd(24'h040021, 1'b1, 16'hbeef, 2, 2, 2);
    $display("data done");
  endtask : t_data
  ////////////////////////////////////////////////////////////////
  initial begin
    {rstn, cyc, stb, we, redirect, fetch_req, byte_mode} = 7'h00;
    {sel, adr, wdat, redirect_addr} = '0;
    fetch_cnt = 2'h1;
    dreq = '0;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_queue();
    t_wait();
    t_data();
    finish_test();
  end
endmodule : pbiu_top_test
